// ==== verilog/system_clock_gear_warmup.sv ====
// Purpose: Core clock source select, gear divider, warm-up timer, halt modes.
// Assumes: Oscillator levels arrive synchronous to core_clk_i, which runs
//          well above both oscillators.
// Notes:   Core clock is produced as a toggling flop, half the geared rate.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// RULE1: Source select 0 high oscillator, 1 low.
// RULE2: Gear codes divide high clock 1..16.
// RULE3: Each oscillator has its own enable.
// RULE4: Reset: high on, low off, gear 000.
// RULE5: High source: core derives from geared clock.
// RULE6: Warm-up select picks 2^18/2^8/2^14/2^16 edges.
// RULE7: Warm-up counts edges of the rising oscillator.
// RULE8: Writing one starts warm-up; reads busy.
// RULE9: Software warms up before changing source.
// RULE10: Stable external oscillators need no warm-up.
// RULE11: Halt field picks stop or idle modes.
// RULE12: Deep stop: pins off unless hold set.
// RULE13: Clock output: low clock or core clock.
// RULE14: Unimplemented bits read as undefined; the code reads them as zero.
// RULE15: Software avoids baud generator on divided prescaler.
// RULE16: Source and gear changes never glitch.
module system_clock_gear_warmup #(
    parameter int WARM_BITS_0 = clock_gear_pkg::WARM_BITS_SEL0,
    parameter int WARM_BITS_1 = clock_gear_pkg::WARM_BITS_SEL1,
    parameter int WARM_BITS_2 = clock_gear_pkg::WARM_BITS_SEL2,
    parameter int WARM_BITS_3 = clock_gear_pkg::WARM_BITS_SEL3
) (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [9:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        high_osc_clk_i,
    input  wire logic        low_osc_clk_i,
    input  wire logic        halt_req_i,
    input  wire logic        wake_i,
    output logic             high_osc_enable_o,
    output logic             low_osc_enable_o,
    output logic             prescaler_source_select_o,
    output logic             core_clock_o,
    output logic             clock_output_pin_o,
    output logic             stop_mode_o,
    output logic             idle_osc_only_o,
    output logic             idle_cpu_only_o,
    output logic             pin_io_off_o,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // State.
    clock_gear_pkg::osc_ctrl_type    osc_q, osc_d;
    clock_gear_pkg::src_gear_type    sg_q, sg_d;
    clock_gear_pkg::src_gear_type    act_q, act_d;
    clock_gear_pkg::misc_type        misc_q, misc_d;
    clock_gear_pkg::power_state_type pwr_q, pwr_d;
    logic [1:0]  irq_stat_q, irq_stat_d;
    logic [1:0]  irq_mask_q, irq_mask_d;
    logic        irq_q, irq_d;
    logic [3:0]  mode_q, mode_d;
    logic        wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic        hosc_q, hosc_prev_q;
    logic        losc_q, losc_prev_q;
    logic [3:0]  div_q, div_d;
    logic        core_q, core_d;
    logic        clkout_q, clkout_d;
    logic        busy_q, busy_d;
    logic        warm_on_low_q, warm_on_low_d;
    logic [clock_gear_pkg::WARM_CNT_W-1:0] warm_cnt_q, warm_cnt_d;

    ////////////////////////////////////////////////////////////////////////
    // Decode and edge detection.
    logic       req;
    logic       wr_take;
    logic       sel_osc;
    logic       sel_sg;
    logic       sel_misc;
    logic       sel_stat;
    logic       sel_mask;
    logic [7:0] wbyte;
    logic       high_tick;
    logic       low_tick;
    logic       geared_tick;
    logic       warm_tick;
    logic [3:0] gear_last;
    logic [clock_gear_pkg::WARM_CNT_W-1:0] warm_last;
    logic       warm_done;
    logic       swap_ev;

    assign req      = avs_read_i | avs_write_i;
    assign wr_take  = avs_write_i & ~wait_q & avs_byteenable_i[0];
    assign sel_osc  = avs_address_i == {clock_gear_pkg::IDX_OSC_CTRL, 2'b00};
    assign sel_sg   = avs_address_i == {clock_gear_pkg::IDX_SRC_GEAR, 2'b00};
    assign sel_misc = avs_address_i == {clock_gear_pkg::IDX_MISC, 2'b00};
    assign sel_stat = avs_address_i == {clock_gear_pkg::IDX_IRQ_STATUS, 2'b00};
    assign sel_mask = avs_address_i == {clock_gear_pkg::IDX_IRQ_MASK, 2'b00};
    assign wbyte    = avs_writedata_i[7:0];

    // Stopped oscillators deliver no edges; deep stop halts both.
    assign high_tick = hosc_q & ~hosc_prev_q & osc_q.high_osc_enable // RULE3
                       & (pwr_q != clock_gear_pkg::PWR_STOP);
    assign low_tick  = losc_q & ~losc_prev_q & osc_q.low_osc_enable // RULE3
                       & (pwr_q != clock_gear_pkg::PWR_STOP);

    always_comb
    begin
        unique case (act_q.gear_divider_select) // RULE2
            3'h0:    gear_last = 4'h0;
            3'h1:    gear_last = 4'h1;
            3'h2:    gear_last = 4'h3;
            3'h3:    gear_last = 4'h7;
            3'h4:    gear_last = 4'hF;
            default: gear_last = 4'h0;
        endcase
    end

    // Geared clock from the chosen source.
    assign geared_tick = act_q.clock_source_select ? low_tick // RULE1
                       : (high_tick & (div_q == gear_last)); // RULE5

    always_comb
    begin
        unique case (misc_q.warmup_length_select) // RULE6
            2'h0: warm_last = clock_gear_pkg::WARM_CNT_W'((1 << WARM_BITS_0) - 1);
            2'h1: warm_last = clock_gear_pkg::WARM_CNT_W'((1 << WARM_BITS_1) - 1);
            2'h2: warm_last = clock_gear_pkg::WARM_CNT_W'((1 << WARM_BITS_2) - 1);
            2'h3: warm_last = clock_gear_pkg::WARM_CNT_W'((1 << WARM_BITS_3) - 1);
        endcase
    end

    // The timer runs on the oscillator being brought up.
    assign warm_tick = warm_on_low_q ? low_tick : high_tick; // RULE7
    assign warm_done = busy_q & warm_tick & (warm_cnt_q == warm_last);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave and registers.
    always_comb
    begin
        osc_d         = osc_q;
        sg_d          = sg_q;
        misc_d        = misc_q;
        irq_mask_d    = irq_mask_q;
        wait_d        = ~(req & wait_q);
        rdata_d       = rdata_q;
        busy_d        = busy_q;
        warm_on_low_d = warm_on_low_q;
        warm_cnt_d    = warm_cnt_q;
        if (busy_q && warm_tick)
        begin
            warm_cnt_d = warm_cnt_q + 1'b1;
        end
        if (warm_done)
        begin
            busy_d = 1'b0; // RULE8
        end
        if (wr_take && sel_osc)
        begin
            osc_d.high_osc_enable = wbyte[clock_gear_pkg::POS_HIGH_EN]; // RULE3
            osc_d.low_osc_enable  = wbyte[clock_gear_pkg::POS_LOW_EN];
            osc_d.prescaler_source_select =
                wbyte[clock_gear_pkg::POS_PRESCALER];
            if (wbyte[clock_gear_pkg::POS_WARMUP])
            begin
                busy_d        = 1'b1; // RULE8
                warm_cnt_d    = '0;
                warm_on_low_d = ~sg_q.clock_source_select; // RULE7
            end
        end
        if (wr_take && sel_sg)
        begin
            sg_d.clock_source_select =
                wbyte[clock_gear_pkg::POS_SRC_SEL]; // RULE1
            sg_d.gear_divider_select =
                wbyte[clock_gear_pkg::POS_GEAR_LSB +: 3]; // RULE2
        end
        if (wr_take && sel_misc)
        begin
            misc_d.out_sel              = wbyte[clock_gear_pkg::POS_OUT_SEL];
            misc_d.warmup_length_select = wbyte[clock_gear_pkg::POS_WARM_LSB +: 2];
            misc_d.sleep_mode_select = wbyte[clock_gear_pkg::POS_SLEEP_LSB +: 2];
            misc_d.stop_pin_hold        = wbyte[clock_gear_pkg::POS_PIN_HOLD];
        end
        if (wr_take && sel_mask)
        begin
            irq_mask_d = wbyte[1:0];
        end
        // Unimplemented and unmapped bits read as zero.
        if (avs_read_i && wait_q)
        begin
            rdata_d = '0; // RULE14
            if (sel_osc)
            begin
                rdata_d[clock_gear_pkg::POS_HIGH_EN]   = osc_q.high_osc_enable;
                rdata_d[clock_gear_pkg::POS_LOW_EN]    = osc_q.low_osc_enable;
                rdata_d[clock_gear_pkg::POS_WARMUP]    = busy_q; // RULE8
                rdata_d[clock_gear_pkg::POS_PRESCALER] =
                    osc_q.prescaler_source_select;
            end
            else if (sel_sg)
            begin
                rdata_d[clock_gear_pkg::POS_SRC_SEL] = sg_q.clock_source_select;
                rdata_d[clock_gear_pkg::POS_GEAR_LSB +: 3] =
                    sg_q.gear_divider_select;
            end
            else if (sel_misc)
            begin
                rdata_d[clock_gear_pkg::POS_OUT_SEL]       = misc_q.out_sel;
                rdata_d[clock_gear_pkg::POS_WARM_LSB +: 2] =
                    misc_q.warmup_length_select;
                rdata_d[clock_gear_pkg::POS_SLEEP_LSB +: 2] =
                    misc_q.sleep_mode_select;
                rdata_d[clock_gear_pkg::POS_PIN_HOLD] = misc_q.stop_pin_hold;
            end
            else if (sel_stat)
            begin
                rdata_d[1:0] = irq_stat_q;
            end
            else if (sel_mask)
            begin
                rdata_d[1:0] = irq_mask_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core clock generation and glitch-free switching.
    always_comb
    begin
        act_d   = act_q;
        div_d   = div_q;
        core_d  = core_q;
        swap_ev = 1'b0;
        if (!act_q.clock_source_select && high_tick)
        begin
            div_d = (div_q == gear_last) ? 4'h0 : div_q + 4'h1;
        end
        if (geared_tick)
        begin
            core_d = ~core_q;
            // New settings take effect only after a falling edge, so
            // every high and low phase is whole.
            if (core_q)
            begin
                act_d   = sg_q; // RULE16
                div_d   = 4'h0;
                if (sg_q.gear_divider_select > clock_gear_pkg::GEAR_MAX)
                begin
                    act_d.gear_divider_select = act_q.gear_divider_select;
                end
                swap_ev = act_d != act_q;
            end
        end
        clkout_d = misc_q.out_sel ? core_d : losc_q; // RULE13
    end

    ////////////////////////////////////////////////////////////////////////
    // Halt modes and interrupts.
    always_comb
    begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            clock_gear_pkg::PWR_RUN:
                if (halt_req_i)
                begin
                    unique case (misc_q.sleep_mode_select) // RULE11
                        clock_gear_pkg::SLEEP_STOP:
                            pwr_d = clock_gear_pkg::PWR_STOP;
                        clock_gear_pkg::SLEEP_IDLE_OS:
                            pwr_d = clock_gear_pkg::PWR_IDLE_OSC;
                        clock_gear_pkg::SLEEP_IDLE_CP:
                            pwr_d = clock_gear_pkg::PWR_IDLE_CPU;
                        default:
                            pwr_d = clock_gear_pkg::PWR_RUN;
                    endcase
                end
            clock_gear_pkg::PWR_STOP,
            clock_gear_pkg::PWR_IDLE_OSC,
            clock_gear_pkg::PWR_IDLE_CPU:
                if (wake_i)
                begin
                    pwr_d = clock_gear_pkg::PWR_RUN;
                end
        endcase
        // Mode pins: stop, osc-only idle, cpu-only idle, pins off.
        mode_d[3] = pwr_d == clock_gear_pkg::PWR_STOP;
        mode_d[2] = pwr_d == clock_gear_pkg::PWR_IDLE_OSC;
        mode_d[1] = pwr_d == clock_gear_pkg::PWR_IDLE_CPU;
        mode_d[0] = mode_d[3] & ~misc_d.stop_pin_hold; // RULE12
        // A new event wins over a write-one clear in the same cycle.
        irq_stat_d = irq_stat_q;
        if (wr_take && sel_stat)
        begin
            irq_stat_d = irq_stat_q & ~wbyte[1:0];
        end
        if (warm_done)
        begin
            irq_stat_d[clock_gear_pkg::POS_IRQ_WARM] = 1'b1;
        end
        if (swap_ev)
        begin
            irq_stat_d[clock_gear_pkg::POS_IRQ_SWAP] = 1'b1;
        end
        irq_d = |(irq_stat_d & irq_mask_d);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            osc_q <= '{clock_gear_pkg::RST_HIGH_EN, // RULE4
                       clock_gear_pkg::RST_LOW_EN, 1'b0};
            sg_q  <= '{clock_gear_pkg::RST_SRC_SEL, clock_gear_pkg::RST_GEAR};
            act_q <= '{clock_gear_pkg::RST_SRC_SEL, clock_gear_pkg::RST_GEAR};
            misc_q <= '{clock_gear_pkg::RST_OUT_SEL,
                        clock_gear_pkg::RST_WARM_SEL,
                        clock_gear_pkg::RST_SLEEP,
                        clock_gear_pkg::RST_PIN_HOLD};
            pwr_q         <= clock_gear_pkg::PWR_RUN;
            irq_stat_q    <= 2'h0;
            irq_mask_q    <= 2'h0;
            irq_q         <= 1'b0;
            mode_q        <= 4'h0;
            wait_q        <= 1'b1;
            rdata_q       <= 32'h0;
            hosc_q        <= 1'b0;
            hosc_prev_q   <= 1'b0;
            losc_q        <= 1'b0;
            losc_prev_q   <= 1'b0;
            div_q         <= 4'h0;
            core_q        <= 1'b0;
            clkout_q      <= 1'b0;
            busy_q        <= 1'b0;
            warm_on_low_q <= 1'b0;
            warm_cnt_q    <= '0;
        end
        else
        begin
            osc_q         <= osc_d;
            sg_q          <= sg_d;
            act_q         <= act_d;
            misc_q        <= misc_d;
            pwr_q         <= pwr_d;
            irq_stat_q    <= irq_stat_d;
            irq_mask_q    <= irq_mask_d;
            irq_q         <= irq_d;
            mode_q        <= mode_d;
            wait_q        <= wait_d;
            rdata_q       <= rdata_d;
            hosc_q        <= high_osc_clk_i;
            hosc_prev_q   <= hosc_q;
            losc_q        <= low_osc_clk_i;
            losc_prev_q   <= losc_q;
            div_q         <= div_d;
            core_q        <= core_d;
            clkout_q      <= clkout_d;
            busy_q        <= busy_d;
            warm_on_low_q <= warm_on_low_d;
            warm_cnt_q    <= warm_cnt_d;
        end
    end

    assign avs_readdata_o            = rdata_q;
    assign avs_waitrequest_o         = wait_q;
    assign high_osc_enable_o         = osc_q.high_osc_enable;
    assign low_osc_enable_o          = osc_q.low_osc_enable;
    assign prescaler_source_select_o = osc_q.prescaler_source_select;
    assign core_clock_o              = core_q;
    assign clock_output_pin_o        = clkout_q;
    assign stop_mode_o     = mode_q[3];
    assign idle_osc_only_o = mode_q[2];
    assign idle_cpu_only_o = mode_q[1];
    assign pin_io_off_o    = mode_q[0]; // RULE12
    assign irq_o           = irq_q;

endmodule : system_clock_gear_warmup
`default_nettype wire

// ==== shared/clock_gear_pkg.sv ====
// Purpose: Constants and types for the system clock gear and warm-up block.
// Assumes: Registers sit in byte lane 0 of a 32-bit Avalon-MM word.
// Notes:   Register byte address is four times the register index.
package clock_gear_pkg;

    // Register indices; byte address = index * 4.
    localparam logic [7:0] IDX_OSC_CTRL   = 8'hE0;
    localparam logic [7:0] IDX_SRC_GEAR   = 8'hE1;
    localparam logic [7:0] IDX_MISC       = 8'hE2;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hE8;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'hE9;

    // Oscillator control field positions.
    localparam int POS_HIGH_EN   = 7;
    localparam int POS_LOW_EN    = 6;
    localparam int POS_WARMUP    = 2;
    localparam int POS_PRESCALER = 1;
    // Source and gear field positions.
    localparam int POS_SRC_SEL   = 3;
    localparam int POS_GEAR_LSB  = 0;
    // Miscellaneous field positions.
    localparam int POS_OUT_SEL   = 6;
    localparam int POS_WARM_LSB  = 4;
    localparam int POS_SLEEP_LSB = 2;
    localparam int POS_PIN_HOLD  = 0;
    // Interrupt bits.
    localparam int POS_IRQ_WARM  = 0;
    localparam int POS_IRQ_SWAP  = 1;

    // Reset values.
    localparam logic       RST_HIGH_EN   = 1'b1;
    localparam logic       RST_LOW_EN    = 1'b0;
    localparam logic       RST_SRC_SEL   = 1'b0;
    localparam logic [2:0] RST_GEAR      = 3'h0;
    localparam logic       RST_OUT_SEL   = 1'b0;
    localparam logic [1:0] RST_WARM_SEL  = 2'h2;
    localparam logic [1:0] RST_SLEEP     = 2'h3;
    localparam logic       RST_PIN_HOLD  = 1'b0;

    // Warm-up lengths as powers of two of oscillator edges.
    localparam int WARM_BITS_SEL0 = 18;
    localparam int WARM_BITS_SEL1 = 8;
    localparam int WARM_BITS_SEL2 = 14;
    localparam int WARM_BITS_SEL3 = 16;
    localparam int WARM_CNT_W     = 18;

    // Gear and sleep encodings.
    localparam logic [2:0] GEAR_MAX      = 3'h4;
    localparam logic [1:0] SLEEP_STOP    = 2'h1;
    localparam logic [1:0] SLEEP_IDLE_OS = 2'h2;
    localparam logic [1:0] SLEEP_IDLE_CP = 2'h3;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_STOP,
        PWR_IDLE_OSC,
        PWR_IDLE_CPU
    } power_state_type;

    typedef struct packed {
        logic       high_osc_enable;
        logic       low_osc_enable;
        logic       prescaler_source_select;
    } osc_ctrl_type;

    typedef struct packed {
        logic       clock_source_select;
        logic [2:0] gear_divider_select;
    } src_gear_type;

    typedef struct packed {
        logic       out_sel;
        logic [1:0] warmup_length_select;
        logic [1:0] sleep_mode_select;
        logic       stop_pin_hold;
    } misc_type;

endpackage : clock_gear_pkg

// ==== test/system_clock_gear_warmup_asserts.sv ====
// Purpose: Port-level checks on the clock gear and warm-up block.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/10ps
`default_nettype none

module system_clock_gear_warmup_chk (
    input wire logic        core_clk_i,
    input wire logic        resetn_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        halt_req_i,
    input wire logic        wake_i,
    input wire logic        core_clock_o,
    input wire logic        stop_mode_o,
    input wire logic        idle_osc_only_o,
    input wire logic        idle_cpu_only_o,
    input wire logic        pin_io_off_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    wire logic any_halt;
    assign any_halt = stop_mode_o | idle_osc_only_o | idle_cpu_only_o;

    AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    AST_ACCEPT: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered after one cycle");
    AST_UPPER_ZERO: assert property (
        !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_ONE_MODE: assert property (
        $onehot0({stop_mode_o, idle_osc_only_o, idle_cpu_only_o}))
        else $error("more than one halt mode active");
    AST_HALT_CAUSE: assert property ($rose(any_halt) |-> $past(halt_req_i))
        else $error("halt mode entered without a halt request");
    AST_WAKE: assert property (wake_i && any_halt |=> !any_halt)
        else $error("wake did not return to run");
    AST_PIN_OFF: assert property (pin_io_off_o |-> stop_mode_o)
        else $error("pin I/O off outside deep stop");
    AST_STOP_FREEZE: assert property (
        stop_mode_o ##1 stop_mode_o |-> $stable(core_clock_o))
        else $error("core clock moved in deep stop");
    AST_CORE_PHASE: assert property (
        $changed(core_clock_o) |=> $stable(core_clock_o))
        else $error("core clock phase shorter than two cycles");
endmodule : system_clock_gear_warmup_chk

bind system_clock_gear_warmup system_clock_gear_warmup_chk u_chk (
    .core_clk_i, .resetn_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
    .avs_waitrequest_o, .halt_req_i, .wake_i, .core_clock_o, .stop_mode_o,
    .idle_osc_only_o, .idle_cpu_only_o, .pin_io_off_o
);

`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the clock gear and warm-up block.
// Assumes: Oscillators are driven as slow synchronous levels.
// Notes:   Warm-up lengths shortened to 2^5, 2^2, 2^3 and 2^4 edges.
`timescale 1ns/10ps
`default_nettype none

module tb;
    localparam logic [7:0] OSC  = clock_gear_pkg::IDX_OSC_CTRL;
    localparam logic [7:0] SRC  = clock_gear_pkg::IDX_SRC_GEAR;
    localparam logic [7:0] MSC  = clock_gear_pkg::IDX_MISC;
    localparam logic [7:0] STAT = clock_gear_pkg::IDX_IRQ_STATUS;
    localparam logic [7:0] MASK = clock_gear_pkg::IDX_IRQ_MASK;
    logic        core_clk_i, resetn_i, avs_read_i, avs_write_i;
    logic [9:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rdat;
    logic [3:0]  avs_byteenable_i;
    logic        avs_waitrequest_o, high_osc_clk_i, low_osc_clk_i;
    logic        halt_req_i, wake_i, high_osc_enable_o, low_osc_enable_o;
    logic        prescaler_source_select_o, core_clock_o, clock_output_pin_o;
    logic        stop_mode_o, idle_osc_only_o, idle_cpu_only_o;
    logic        pin_io_off_o, irq_o, core_prev;
    int          mismatches, n_tests, tog, tog0, n, m, h;
    int          wbits [4] = '{5, 2, 3, 4};
    wire [3:0]   modes = {stop_mode_o, idle_osc_only_o, idle_cpu_only_o,
                          pin_io_off_o};

    system_clock_gear_warmup #(
        .WARM_BITS_0(5), .WARM_BITS_1(2), .WARM_BITS_2(3), .WARM_BITS_3(4)
    ) dut (
        .core_clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .high_osc_clk_i, .low_osc_clk_i, .halt_req_i,
        .wake_i, .high_osc_enable_o, .low_osc_enable_o,
        .prescaler_source_select_o, .core_clock_o, .clock_output_pin_o,
        .stop_mode_o, .idle_osc_only_o, .idle_cpu_only_o, .pin_io_off_o,
        .irq_o
    );

    initial core_clk_i = 1'b0;
    always #2.5 core_clk_i = ~core_clk_i;

    // Counts core clock changes so divide ratios can be measured.
    always @(posedge core_clk_i)
    begin
        core_prev <= core_clock_o;
        if (core_clock_o !== core_prev)
            tog <= tog + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd);
        int k;
        k = 0;
        avs_address_i   <= {idx, 2'b00};
        avs_writedata_i <= {24'h000000, wd};
        avs_write_i     <= w;
        avs_read_i      <= !w;
        @(posedge core_clk_i);
        while (avs_waitrequest_o !== 1'b0)
        begin
            k++;
            if (k > 20)
            begin
                mismatches++;
                $display("CHECK FAILED at %0t: bus timeout", $time);
                end_of_test();
            end
            @(posedge core_clk_i);
        end
        rdat = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge core_clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rdat, exp);
    endtask : rd

    task automatic settle;
        repeat (3) @(posedge core_clk_i);
    endtask : settle

    // Sends cnt rising edges, two cycles high and two low, then idles.
    task automatic pulses(input logic hi, input logic lo, input int cnt);
        repeat (cnt)
        begin
            high_osc_clk_i <= hi;
            low_osc_clk_i  <= lo;
            repeat (2) @(posedge core_clk_i);
            high_osc_clk_i <= 1'b0;
            low_osc_clk_i  <= 1'b0;
            repeat (2) @(posedge core_clk_i);
        end
        repeat (8) @(posedge core_clk_i);
    endtask : pulses

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {avs_read_i, avs_write_i, halt_req_i, wake_i} = 4'h0;
        {high_osc_clk_i, low_osc_clk_i} = 2'h0;
        avs_address_i = 10'h000;
        avs_writedata_i = 32'h00000000;
        avs_byteenable_i = 4'hF;
        resetn_i = 1'b0;
        {mismatches, n_tests} = 64'h0;
        repeat (4) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        @(posedge core_clk_i);
        chk({high_osc_enable_o, low_osc_enable_o}, 2'h2);
        rd(OSC, 32'h80);
        rd(SRC, 32'h00);
        rd(MSC, 32'h2C);
        rd(8'h3F, 32'h00);
        avs_byteenable_i <= 4'h0;
        wr(MSC, 8'h00);
        avs_byteenable_i <= 4'hF;
        rd(MSC, 32'h2C);
        wr(SRC, 8'hF0);
        rd(SRC, 32'h00);
        for (int s = 0; s < 4; s++)
        begin
            wr(MSC, {2'h0, s[1:0], 4'hC});
            n = 1 << wbits[s];
            wr(OSC, 8'hC6);
            chk(prescaler_source_select_o, 1'b1);
            rd(OSC, 32'hC6);
            pulses(1'b1, 1'b0, n);
            rd(OSC, 32'hC6);
            pulses(1'b0, 1'b1, n - 1);
            rd(OSC, 32'hC6);
            pulses(1'b0, 1'b1, 1);
            rd(OSC, 32'hC2);
        end
        low_osc_clk_i <= 1'b1;
        settle;
        chk(clock_output_pin_o, 1'b1);
        low_osc_clk_i <= 1'b0;
        settle;
        chk(clock_output_pin_o, 1'b0);
        wr(MASK, 8'h00);
        settle;
        chk(irq_o, 1'b0);
        rd(STAT, 32'h01);
        wr(MASK, 8'h01);
        settle;
        chk(irq_o, 1'b1);
        wr(STAT, 8'h01);
        settle;
        chk(irq_o, 1'b0);
        rd(STAT, 32'h00);
        wr(SRC, 8'h08);
        pulses(1'b1, 1'b1, 4);
        rd(SRC, 32'h08);
        tog0 = tog;
        pulses(1'b1, 1'b0, 16);
        chk(tog - tog0, 0);
        pulses(1'b0, 1'b1, 16);
        chk(tog - tog0, 16);
        wr(OSC, 8'h40);
        settle;
        chk({high_osc_enable_o, low_osc_enable_o}, 2'h1);
        wr(OSC, 8'hC0);
        wr(SRC, 8'h00);
        pulses(1'b1, 1'b1, 4);
        for (int g = 0; g < 6; g++)
        begin
            wr(SRC, g[7:0]);
            pulses(1'b1, 1'b0, 32);
            if (g < 5) rd(SRC, g);
            tog0 = tog;
            pulses(1'b1, 1'b0, 64);
            chk(tog - tog0, 64 >> ((g > 4) ? 4 : g));
        end
        rd(STAT, 32'h02);
        wr(STAT, 8'h02);
        for (int i = 0; i < 5; i++)
        begin
            m = i - ((i > 1) ? 1 : 0);
            h = (i == 2) ? 1 : 0;
            wr(MSC, {4'h6, m[1:0], 1'b0, h[0]});
            halt_req_i <= 1'b1;
            @(posedge core_clk_i);
            halt_req_i <= 1'b0;
            pulses(1'b1, 1'b0, 4);
            chk(modes, {m == 1, m == 2, m == 3, m == 1 && h == 0});
            wake_i <= 1'b1;
            @(posedge core_clk_i);
            wake_i <= 1'b0;
            settle;
            chk(modes, 4'h0);
            chk(clock_output_pin_o, core_clock_o);
        end
        end_of_test();
    end
endmodule : tb

`default_nettype wire
